/* File: logic/wg_defines.svh */
`ifndef WG_DEFINES_SVH
`define WG_DEFINES_SVH

// ********************************************************
// Register offsets
// ********************************************************
`define WG_ADDR_W 16
`define WG_OFS_CONFIG 16'h2014
`define WG_OFS_LEVEL_ONE 16'h2018
`define WG_OFS_LEVEL_TWO 16'h201c
`define WG_OFS_HOLD_ONE 16'h2020
`define WG_OFS_RAMP_ONE 16'h2024
`define WG_OFS_HOLD_TWO 16'h2028
`define WG_OFS_RAMP_TWO 16'h202c
`define WG_OFS_FREQ_WORD 16'h2030
`define WG_OFS_DIRECT_DATA 16'h2040

// ********************************************************
// Reset values and read masks
// ********************************************************
`define WG_CONFIG_RESET 32'h0000_0030
`define WG_CONFIG_MASK 32'h0000_0036
`define WG_LEVEL_MASK 32'h0000_0fff
`define WG_TIME_MASK 32'h000f_ffff
`define WG_FREQ_MASK 32'h7fff_ffff

// ********************************************************
// Field positions
// ********************************************************
`define WG_CFG_RESTART_BIT 0
`define WG_CFG_TYPE_LSB 1
`define WG_CFG_TYPE_MSB 2
`define WG_CFG_OFFSET_CAL_BIT 4
`define WG_CFG_GAIN_CAL_BIT 5

// ********************************************************
// Widths and rates
// ********************************************************
`define WG_LEVEL_W 12
`define WG_TIME_W 20
`define WG_FREQ_W 31
`define WG_PHASE_W 30
`define WG_ROM_ADDR_W 8
`define WG_CLK_KHZ 25000
`define WG_TRAP_RATE_KHZ 320

`endif

/* File: logic/wg_pkg.sv */
package wg_pkg;

    // Trapezoid phases
    typedef enum logic [1:0] {
        WG_HOLD_ONE = 2'b00,
        WG_RAMP_ONE = 2'b01,
        WG_HOLD_TWO = 2'b10,
        WG_RAMP_TWO = 2'b11
    } wg_phase_e;

    // Output source select
    typedef enum logic [1:0] {
        WG_SRC_DIRECT = 2'b00,
        WG_SRC_SPARE = 2'b01,
        WG_SRC_SINE = 2'b10,
        WG_SRC_TRAP = 2'b11
    } wg_source_e;

endpackage

/* File: logic/wg_rate_tick.sv */
`timescale 1ns/1ns
`include "wg_defines.svh"

module wg_rate_tick
#(
    parameter int CLK_KHZ = `WG_CLK_KHZ,
    parameter int RATE_KHZ = `WG_TRAP_RATE_KHZ,
    parameter int ACC_W = 16
)
(
    // Clock and reset
    input logic clk,
    input logic reset,
    // Control
    input logic run,
    // Update enable
    output logic tick_q
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0] sum_w;

    // Fractional divider keeps the average rate exact
    assign sum_w = {1'b0, acc_q} + (ACC_W+1)'(RATE_KHZ);

    always_ff @(posedge clk or posedge reset)
    begin
        // Preload one step so the first tick lands one rate period after start
        if (reset)
        begin
            acc_q <= ACC_W'(RATE_KHZ);
            tick_q <= 1'b0;
        end
        else if (!run)
        begin
            acc_q <= ACC_W'(RATE_KHZ);
            tick_q <= 1'b0;
        end
        else if (sum_w >= (ACC_W+1)'(CLK_KHZ))
        begin
            acc_q <= ACC_W'(sum_w - (ACC_W+1)'(CLK_KHZ));
            tick_q <= 1'b1;
        end
        else
        begin
            acc_q <= sum_w[ACC_W-1:0];
            tick_q <= 1'b0;
        end
    end

endmodule

/* File: logic/wg_sine_rom.sv */
`timescale 1ns/1ns
`include "wg_defines.svh"

module wg_sine_rom
#(
    parameter int ADDR_W = `WG_ROM_ADDR_W,
    parameter int DATA_W = `WG_LEVEL_W
)
(
    // Clock
    input logic clk,
    // Read port
    input logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data_q
);

    // Rational sine approximation, offset binary
    function automatic logic [DATA_W-1:0] sine_point(input int idx);
        int half;
        int n;
        int p;
        int full;
        int mag;
        half = 2 ** (ADDR_W - 1);
        n = idx % half;
        p = n * (half - n);
        full = 2 ** (DATA_W - 1) - 1;
        mag = (full * 16 * p) / (5 * half * half - 4 * p);
        if (idx < half)
            return DATA_W'(full + 1 + mag);
        return DATA_W'(full + 1 - mag);
    endfunction

    logic [DATA_W-1:0] table_w [2**ADDR_W];

    for (genvar i = 0; i < 2**ADDR_W; i++)
    begin : g_point
        assign table_w[i] = sine_point(i);
    end

    always_ff @(posedge clk)
    begin
        data_q <= table_w[addr];
    end

endmodule

/* File: logic/wg_core.sv */
// Operation
// - A 12-bit second plateau level sets the output during the second hold.
// - The first hold lasts a 20-bit count of DAC updates.
// - The first ramp lasts a 20-bit count of DAC updates.
// - The second hold lasts a 20-bit count of DAC updates.
// - The second ramp lasts a 20-bit count of DAC updates.
// - Trapezoid DAC updates come at a fixed 320 kHz, one per count.
// - A 31-bit frequency word sets the sine frequency through its low 30 bits.
// - Sine frequency is clock times the low 30 bits of the frequency word over two to the 30.
// - A 2-bit select picks direct, sine or trapezoid; the latter two set enable.
// - Writing the restart bit restarts the trapezoid at hold one; it self-clears.
// - A 12-bit first plateau level sets the output during the first hold.
`timescale 1ns/1ns
`include "wg_defines.svh"

module wg_core
(
    // Clock and reset
    input logic clk,
    input logic reset,
    // Register port
    input logic reg_wr,
    input logic reg_rd,
    input logic [`WG_ADDR_W-1:0] reg_addr,
    input logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // DAC sample output
    output logic [`WG_LEVEL_W-1:0] dac_data_q,
    output logic dac_update_q,
    // Status toward the analog front end
    output logic generator_enable_q,
    output logic gain_cal_enable_q,
    output logic offset_cal_enable_q
);

    // ********************************************************
    // Decode
    // ********************************************************
    function automatic logic [31:0] wg_read_mask(input logic [`WG_ADDR_W-1:0] addr);
        case (addr)
            `WG_OFS_CONFIG: return `WG_CONFIG_MASK;
            `WG_OFS_LEVEL_ONE: return `WG_LEVEL_MASK;
            `WG_OFS_LEVEL_TWO: return `WG_LEVEL_MASK;
            `WG_OFS_HOLD_ONE: return `WG_TIME_MASK;
            `WG_OFS_RAMP_ONE: return `WG_TIME_MASK;
            `WG_OFS_HOLD_TWO: return `WG_TIME_MASK;
            `WG_OFS_RAMP_TWO: return `WG_TIME_MASK;
            `WG_OFS_FREQ_WORD: return `WG_FREQ_MASK;
            `WG_OFS_DIRECT_DATA: return `WG_LEVEL_MASK;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [`WG_TIME_W-1:0] wg_at_least_one(input logic [`WG_TIME_W-1:0] n);
        return (n == '0) ? `WG_TIME_W'(1) : n;
    endfunction

    // ********************************************************
    // Registers
    // ********************************************************
    wg_pkg::wg_source_e waveform_select_q;
    logic [`WG_LEVEL_W-1:0] level1_q;
    logic [`WG_LEVEL_W-1:0] level2_q;
    logic [`WG_TIME_W-1:0] hold1_q;
    logic [`WG_TIME_W-1:0] ramp1_q;
    logic [`WG_TIME_W-1:0] hold2_q;
    logic [`WG_TIME_W-1:0] ramp2_q;
    logic [`WG_FREQ_W-1:0] fcw_q;
    logic cfg_wr_w;
    logic direct_wr_w;
    logic restart_w;
    logic trap_run_w;
    logic sine_run_w;

    assign cfg_wr_w = reg_wr && (reg_addr == `WG_OFS_CONFIG);
    assign direct_wr_w = reg_wr && (reg_addr == `WG_OFS_DIRECT_DATA);
    assign trap_run_w = (waveform_select_q == wg_pkg::WG_SRC_TRAP);
    assign sine_run_w = (waveform_select_q == wg_pkg::WG_SRC_SINE);
    assign restart_w = cfg_wr_w && reg_wdata[`WG_CFG_RESTART_BIT];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            waveform_select_q <= wg_pkg::WG_SRC_DIRECT;
            generator_enable_q <= 1'b0;
            gain_cal_enable_q <= 1'(`WG_CONFIG_RESET >> `WG_CFG_GAIN_CAL_BIT);
            offset_cal_enable_q <= 1'(`WG_CONFIG_RESET >> `WG_CFG_OFFSET_CAL_BIT);
        end
        else if (cfg_wr_w)
        begin
            waveform_select_q <= wg_pkg::wg_source_e'(reg_wdata[`WG_CFG_TYPE_MSB:`WG_CFG_TYPE_LSB]);
            generator_enable_q <= reg_wdata[`WG_CFG_TYPE_MSB];
            gain_cal_enable_q <= reg_wdata[`WG_CFG_GAIN_CAL_BIT];
            offset_cal_enable_q <= reg_wdata[`WG_CFG_OFFSET_CAL_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            level1_q <= '0;
            level2_q <= '0;
            hold1_q <= '0;
            ramp1_q <= '0;
            hold2_q <= '0;
            ramp2_q <= '0;
            fcw_q <= '0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `WG_OFS_LEVEL_ONE: level1_q <= reg_wdata[`WG_LEVEL_W-1:0];
                `WG_OFS_LEVEL_TWO: level2_q <= reg_wdata[`WG_LEVEL_W-1:0];
                `WG_OFS_HOLD_ONE: hold1_q <= reg_wdata[`WG_TIME_W-1:0];
                `WG_OFS_RAMP_ONE: ramp1_q <= reg_wdata[`WG_TIME_W-1:0];
                `WG_OFS_HOLD_TWO: hold2_q <= reg_wdata[`WG_TIME_W-1:0];
                `WG_OFS_RAMP_TWO: ramp2_q <= reg_wdata[`WG_TIME_W-1:0];
                `WG_OFS_FREQ_WORD: fcw_q <= reg_wdata[`WG_FREQ_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // ********************************************************
    // Register read
    // ********************************************************
    logic [31:0] rd_value_w;

    always_comb
    begin
        rd_value_w = 32'h0;
        case (reg_addr)
            `WG_OFS_CONFIG: rd_value_w = {26'h0, gain_cal_enable_q, offset_cal_enable_q,
                1'b0, waveform_select_q, 1'b0};
            `WG_OFS_LEVEL_ONE: rd_value_w = {20'h0, level1_q};
            `WG_OFS_LEVEL_TWO: rd_value_w = {20'h0, level2_q};
            `WG_OFS_HOLD_ONE: rd_value_w = {12'h0, hold1_q};
            `WG_OFS_RAMP_ONE: rd_value_w = {12'h0, ramp1_q};
            `WG_OFS_HOLD_TWO: rd_value_w = {12'h0, hold2_q};
            `WG_OFS_RAMP_TWO: rd_value_w = {12'h0, ramp2_q};
            `WG_OFS_FREQ_WORD: rd_value_w = {1'b0, fcw_q};
            `WG_OFS_DIRECT_DATA: rd_value_w = {20'h0, dac_data_q};
            default: rd_value_w = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata_q <= 32'h0;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rd_value_w & wg_read_mask(reg_addr);
        end
    end

    // ********************************************************
    // Trapezoid sequencer
    // ********************************************************
    wg_pkg::wg_phase_e phase_q;
    logic [`WG_TIME_W-1:0] cnt_q;
    logic [`WG_TIME_W-1:0] len_w;
    logic phase_done_w;
    logic tick_w;
    logic [`WG_LEVEL_W-1:0] ramp_from_w;
    logic [`WG_LEVEL_W-1:0] ramp_to_w;
    logic [`WG_TIME_W:0] step_w;
    logic signed [`WG_LEVEL_W:0] diff_w;
    logic signed [34:0] quot_w;
    logic signed [34:0] sum_w;
    logic [`WG_LEVEL_W-1:0] trap_val_w;

    wg_rate_tick u_rate
    (
        .clk(clk),
        .reset(reset),
        .run(trap_run_w && !restart_w),
        .tick_q(tick_w)
    );

    always_comb
    begin
        unique case (phase_q)
            wg_pkg::WG_HOLD_ONE: len_w = wg_at_least_one(hold1_q);
            wg_pkg::WG_RAMP_ONE: len_w = wg_at_least_one(ramp1_q);
            wg_pkg::WG_HOLD_TWO: len_w = wg_at_least_one(hold2_q);
            wg_pkg::WG_RAMP_TWO: len_w = wg_at_least_one(ramp2_q);
        endcase
    end

    assign step_w = {1'b0, cnt_q} + 21'h1;
    assign phase_done_w = (step_w >= {1'b0, len_w});
    assign ramp_from_w = (phase_q == wg_pkg::WG_RAMP_ONE) ? level1_q : level2_q;
    assign ramp_to_w = (phase_q == wg_pkg::WG_RAMP_ONE) ? level2_q : level1_q;
    assign diff_w = $signed({1'b0, ramp_to_w}) - $signed({1'b0, ramp_from_w});
    assign quot_w = (diff_w * $signed({1'b0, step_w})) / $signed({2'b0, len_w});
    assign sum_w = $signed({23'h0, ramp_from_w}) + quot_w;

    always_comb
    begin
        unique case (phase_q)
            wg_pkg::WG_HOLD_ONE: trap_val_w = level1_q;
            wg_pkg::WG_HOLD_TWO: trap_val_w = level2_q;
            wg_pkg::WG_RAMP_ONE,
            wg_pkg::WG_RAMP_TWO: trap_val_w = sum_w[`WG_LEVEL_W-1:0];
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase_q <= wg_pkg::WG_HOLD_ONE;
            cnt_q <= '0;
        end
        else if (restart_w || !trap_run_w)
        begin
            phase_q <= wg_pkg::WG_HOLD_ONE;
            cnt_q <= '0;
        end
        else if (tick_w)
        begin
            if (phase_done_w)
            begin
                phase_q <= wg_pkg::wg_phase_e'(phase_q + 2'h1);
                cnt_q <= '0;
            end
            else
                cnt_q <= step_w[`WG_TIME_W-1:0];
        end
    end

    // ********************************************************
    // Sine phase accumulator
    // ********************************************************
    logic [`WG_PHASE_W-1:0] phase_acc_q;
    logic [`WG_LEVEL_W-1:0] rom_data_w;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            phase_acc_q <= '0;
        else if (sine_run_w)
            phase_acc_q <= phase_acc_q + fcw_q[`WG_PHASE_W-1:0];
        else
            phase_acc_q <= '0;
    end

    wg_sine_rom u_rom
    (
        .clk(clk),
        .addr(phase_acc_q[`WG_PHASE_W-1 -: `WG_ROM_ADDR_W]),
        .data_q(rom_data_w)
    );

    // ********************************************************
    // DAC output
    // ********************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dac_data_q <= '0;
            dac_update_q <= 1'b0;
        end
        else
        begin
            dac_update_q <= 1'b0;
            unique case (waveform_select_q)
                wg_pkg::WG_SRC_TRAP:
                begin
                    if (restart_w)
                    begin
                        dac_data_q <= level1_q;
                        dac_update_q <= 1'b1;
                    end
                    else if (tick_w)
                    begin
                        dac_data_q <= trap_val_w;
                        dac_update_q <= 1'b1;
                    end
                end
                wg_pkg::WG_SRC_SINE:
                begin
                    dac_data_q <= rom_data_w;
                    dac_update_q <= 1'b1;
                end
                wg_pkg::WG_SRC_DIRECT:
                begin
                    if (direct_wr_w)
                    begin
                        dac_data_q <= reg_wdata[`WG_LEVEL_W-1:0];
                        dac_update_q <= 1'b1;
                    end
                end
                wg_pkg::WG_SRC_SPARE:
                begin
                end
            endcase
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    localparam int TickGapMin = `WG_CLK_KHZ / `WG_TRAP_RATE_KHZ;
    logic [7:0] gap_q;
    logic seen_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end
        else if (!trap_run_w || restart_w)
        begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end
        else if (tick_w)
        begin
            gap_q <= '0;
            seen_q <= 1'b1;
        end
        else
            gap_q <= gap_q + 8'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence restart_seen;
        restart_w && trap_run_w;
    endsequence

    sequence back_to_level_one;
        phase_q == wg_pkg::WG_HOLD_ONE && cnt_q == '0 && dac_data_q == level1_q;
    endsequence

    level_two_store_a: assert property (reg_wr && reg_addr == `WG_OFS_LEVEL_TWO ##2 reg_rd && reg_addr == `WG_OFS_LEVEL_TWO |=> reg_rdata_q == {20'h0, $past(reg_wdata[11:0], 3)}) else $error("Level two readback wrong");
    hold_one_len_a: assert property ($changed(phase_q) && phase_q == wg_pkg::WG_RAMP_ONE |-> $past(cnt_q) + 20'h1 == wg_at_least_one($past(hold1_q))) else $error("Hold one length wrong");
    ramp_one_end_a: assert property ($changed(phase_q) && phase_q == wg_pkg::WG_HOLD_TWO |-> dac_data_q == $past(level2_q)) else $error("Ramp one did not end at level two");
    hold_two_len_a: assert property ($changed(phase_q) && phase_q == wg_pkg::WG_RAMP_TWO |-> $past(cnt_q) + 20'h1 == wg_at_least_one($past(hold2_q))) else $error("Hold two length wrong");
    ramp_two_end_a: assert property ($past(trap_run_w) && trap_run_w && $past(phase_q) == wg_pkg::WG_RAMP_TWO && phase_q == wg_pkg::WG_HOLD_ONE |-> dac_data_q == $past(level1_q)) else $error("Ramp two did not end at level one");
    trap_rate_a: assert property (tick_w && seen_q && trap_run_w |-> gap_q == 8'(TickGapMin - 1) || gap_q == 8'(TickGapMin)) else $error("Trapezoid update spacing wrong");
    freq_word_a: assert property (reg_wr && reg_addr == `WG_OFS_FREQ_WORD |=> fcw_q == $past(reg_wdata[30:0])) else $error("Frequency word not stored");
    sine_phase_a: assert property (sine_run_w [*3] |-> phase_acc_q == 30'($past(phase_acc_q, 2) + $past(fcw_q[29:0], 2) + $past(fcw_q[29:0]))) else $error("Sine phase step wrong");
    gen_enable_mode_a: assert property (generator_enable_q == waveform_select_q[1] && (dac_update_q && $past(waveform_select_q) == wg_pkg::WG_SRC_DIRECT -> $past(direct_wr_w))) else $error("Source select mismatch");
    trap_restart_a: assert property (restart_seen |=> back_to_level_one) else $error("Restart did not return to level one");
    hold_one_level_a: assert property (tick_w && trap_run_w && !restart_w && phase_q == wg_pkg::WG_HOLD_ONE |=> dac_data_q == $past(level1_q)) else $error("Hold one level wrong");
    phase_order_a: assert property ($changed(phase_q) && phase_q != wg_pkg::WG_HOLD_ONE |-> 2'(phase_q) == 2'($past(phase_q)) + 2'h1) else $error("Phase order wrong");
    reserved_zero_a: assert property (reg_rvalid_q |-> (reg_rdata_q & ~wg_read_mask($past(reg_addr))) == 32'h0) else $error("Reserved bits read nonzero");

endmodule

/* File: test/wg_dac_sink.sv */
`timescale 1ns/1ns
`include "wg_defines.svh"

// ********************************
// DAC sample input model
// ********************************
module wg_dac_sink
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Sample input
    input wire logic [`WG_LEVEL_W-1:0] dac_data,
    input wire logic dac_update,
    // Captured sample and gap
    output logic [`WG_LEVEL_W-1:0] sample_q,
    output logic sample_valid_q,
    output logic [15:0] gap_q
);
    logic [15:0] cnt_q;

    // Latches each sample and the clocks since the last one
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sample_q <= '0;
            sample_valid_q <= 1'b0;
            gap_q <= 16'h0;
            cnt_q <= 16'h0;
        end
        else
        begin
            sample_valid_q <= dac_update;
            cnt_q <= dac_update ? 16'h1 : cnt_q + 16'h1;
            if (dac_update)
            begin
                sample_q <= dac_data;
                gap_q <= cnt_q;
            end
        end
    end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ns
`include "wg_defines.svh"

module testbench;
    logic clk, reset, reg_wr, reg_rd, reg_rvalid_q, dac_update_q, sample_valid_q, watch;
    logic generator_enable_q, gain_cal_enable_q, offset_cal_enable_q;
    logic [`WG_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q, lfsr_q;
    logic [`WG_LEVEL_W-1:0] dac_data_q, sample_q;
    logic [15:0] gap_q;
    int fails, checked, cycles, upd_n, n;
    logic [31:0] rd_q[$];
    logic [12:0] dac_q[$];
    logic [11:0] seen[128];
    logic [11:0] trap_seq[12] = '{12'h100, 12'h100, 12'h255, 12'h3aa, 12'h4ff, 12'h4ff,
        12'h300, 12'h100, 12'h100, 12'h100, 12'h255, 12'h3aa};
    logic [15:0] addrs[7] = '{`WG_OFS_LEVEL_ONE, `WG_OFS_LEVEL_TWO, `WG_OFS_HOLD_ONE,
        `WG_OFS_RAMP_ONE, `WG_OFS_HOLD_TWO, `WG_OFS_RAMP_TWO, `WG_OFS_FREQ_WORD};
    logic [31:0] masks[7] = '{`WG_LEVEL_MASK, `WG_LEVEL_MASK, `WG_TIME_MASK, `WG_TIME_MASK,
        `WG_TIME_MASK, `WG_TIME_MASK, `WG_FREQ_MASK};

    wg_core dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .dac_data_q(dac_data_q), .dac_update_q(dac_update_q),
        .generator_enable_q(generator_enable_q), .gain_cal_enable_q(gain_cal_enable_q),
        .offset_cal_enable_q(offset_cal_enable_q));

    wg_dac_sink sink (.clk(clk), .reset(reset), .dac_data(dac_data_q),
        .dac_update(dac_update_q), .sample_q(sample_q), .sample_valid_q(sample_valid_q),
        .gap_q(gap_q));

    // ********************************
    // Shared tasks
    // ********************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic drain();
        for (int i = 0; i < 3000 && dac_q.size() > 0; i++)
            @(posedge clk);
        check(32'(dac_q.size()), 32'h0);
    endtask

    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ********************************
    // Clock, timeout and result monitor
    // ********************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fails++;
            summarize();
        end
        if (sample_valid_q === 1'b1)
            upd_n++;
        if (reg_rvalid_q === 1'b1)
            check(reg_rdata_q, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdead_beef);
        if (sample_valid_q === 1'b1 && watch && dac_q.size() > 0)
        begin
            if (dac_q[0][12])
                check(32'(gap_q == 16'd78 || gap_q == 16'd79), 32'h1);
            check(32'(sample_q), 32'(dac_q.pop_front() & 13'hfff));
        end
    end

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        {reg_wr, reg_rd, watch, reg_addr, reg_wdata} = '0;
        {fails, checked, cycles, upd_n} = '0;
        lfsr_q = 32'hab117088;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({30'h0, gain_cal_enable_q, offset_cal_enable_q}, 32'h3);
        rd(`WG_OFS_CONFIG, 32'h30);
        rd(16'h2050, 32'h0);
        for (int i = 0; i < 7; i++)
            rd(addrs[i], 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            wr(addrs[i], lfsr_q);
            rd(addrs[i], lfsr_q & masks[i]);
        end
        wr(16'h2050, 32'hffff_ffff);
        rd(16'h2050, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            wr(`WG_OFS_CONFIG, 32'h30 | 32'(m << 1));
            repeat (2) @(posedge clk);
            check(32'(generator_enable_q), 32'(m >= 2));
            @(negedge clk);
            n = upd_n;
            repeat (200) @(negedge clk);
            if (m == 1)
                check(32'(upd_n), 32'(n));
        end
        wr(`WG_OFS_CONFIG, 32'h30);
        watch = 1'b1;
        lfsr_q = lfsr(lfsr_q);
        dac_q.push_back({1'b0, lfsr_q[11:0]});
        wr(`WG_OFS_DIRECT_DATA, lfsr_q);
        drain();
        for (int p = 64; p <= 128; p += 64)
        begin
            wr(`WG_OFS_FREQ_WORD, 32'h4000_0000 / p);
            wr(`WG_OFS_CONFIG, 32'h34);
            repeat (8) @(posedge clk);
            @(negedge clk);
            n = upd_n;
            for (int i = 0; i < 2 * p; i++)
            begin
                if (i < p)
                    seen[i] = dac_data_q;
                else
                    check(32'(dac_data_q), 32'(seen[i - p]));
                @(negedge clk);
            end
            check(32'(upd_n - n), 32'(2 * p));
            check(32'(seen[p / 4] != seen[3 * p / 4]), 32'h1);
            wr(`WG_OFS_CONFIG, 32'h30);
        end
        wr(`WG_OFS_LEVEL_ONE, 32'h100);
        wr(`WG_OFS_LEVEL_TWO, 32'h4ff);
        wr(`WG_OFS_HOLD_ONE, 32'h2);
        wr(`WG_OFS_RAMP_ONE, 32'h3);
        wr(`WG_OFS_HOLD_TWO, 32'h0);
        wr(`WG_OFS_RAMP_TWO, 32'h2);
        for (int i = 0; i < 12; i++)
            dac_q.push_back({i > 0, trap_seq[i]});
        wr(`WG_OFS_CONFIG, 32'h36);
        drain();
        for (int i = 0; i < 2000 && sample_q !== 12'h3aa; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        dac_q.push_back(13'h0100);
        dac_q.push_back(13'h1100);
        wr(`WG_OFS_CONFIG, 32'h37);
        drain();
        rd(`WG_OFS_CONFIG, 32'h36);
        repeat (4) @(posedge clk);
        summarize();
    end
endmodule
